/* verilog/tone_pair_steering_latch.sv */
// steering and output latch of a dual-tone keypad receiver
//
// Overview of operation
// - inhibit input blocks letter keys A-D
// - power down halts oscillator and all activity but the code bus enable
// - timing derives from crystal-rate oscillator ticks
// - code outputs driven only while enable high
// - outputs hold last registered code
// - early flag rises on valid tone pair
// - early flag drops on any signal loss while not powered down
// - node above threshold registers pair, updates latch
// - node below threshold frees for new pair
// - late flag rises after pair registered
// - late flag drops when node below threshold
// - guard level from early flag and node
// - four-bit code table for sixteen keys
// - guard drives high while early flag and node high, once a pair is registered
// - inhibited letter tone keeps previous code
// - late flag waits for latch settling
`timescale 1ns/1ps
`include "tps_map.svh"
module tone_pair_steering_latch #(
  parameter int SETTLE_TICKS = int'(`TPS_SETTLE_TICKS)
) (
  input  wire logic                mclk,
  input  wire logic                rst_n,
  input  wire logic                power_down_in,
  input  wire logic                letter_tone_inhibit,
  input  wire logic                output_drive_enable,
  input  wire logic                crystal_in,
  output logic                     crystal_out,
  input  wire logic                tone_present,
  input  wire tps_pkg::tps_index_t tone_row,
  input  wire tps_pkg::tps_index_t tone_col,
  input  wire logic                timing_node_in,
  output logic                     guard_drive,
  output logic                     guard_drive_oe_n,
  output tps_pkg::tps_code_t       key_code_out,
  output logic                     key_code_oe_n,
  output logic                     early_valid_flag,
  output logic                     late_valid_flag
);
  import tps_pkg::*;

  // -------------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------------
  localparam logic [`TPS_SETTLE_W-1:0] SETTLE_LOAD = `TPS_SETTLE_W'(SETTLE_TICKS);

  logic [`TPS_PIN_N-1:0] pin_raw;
  logic [`TPS_PIN_N-1:0] pin_sync;

  logic                  inhibit_s;
  logic                  power_down_s;
  logic                  drive_enable_s;
  logic                  node_above_s;
  logic                  crystal_s;
  logic                  run;

  logic [`TPS_ACC_W-1:0] acc_reg;
  logic [`TPS_ACC_W-1:0] acc_next;
  logic [`TPS_ACC_W:0]   acc_sum;
  logic                  acc_wrap;
  logic                  osc_tick;
  logic                  osc_out_reg;

  logic                  pair_ok;
  logic                  early_reg;

  tps_code_t             pend_code_reg;
  logic                  pend_valid_reg;
  logic                  pend_valid_next;

  tps_steer_t            steer_reg;
  tps_steer_t            steer_next;
  logic                  do_register;
  logic                  settle_done;
  logic [`TPS_SETTLE_W-1:0] settle_reg;
  logic [`TPS_SETTLE_W-1:0] settle_next;

  tps_code_t             latch_reg;
  tps_code_t             latch_next;
  logic                  late_reg;
  logic                  late_next;

  logic                  guard_level_next;
  logic                  guard_oe_n_next;
  logic                  guard_level_reg;
  logic                  guard_oe_n_reg;
  logic                  code_oe_n_reg;

  tps_detect_if          det ();

  // -------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------
  assign pin_raw[`TPS_PIN_LETTER] = letter_tone_inhibit;
  assign pin_raw[`TPS_PIN_PD]     = power_down_in;
  assign pin_raw[`TPS_PIN_DRIVE]  = output_drive_enable;
  assign pin_raw[`TPS_PIN_ST]     = timing_node_in;
  assign pin_raw[`TPS_PIN_CRY]    = crystal_in;

  tps_pin_sync #(
    .WIDTH   (`TPS_PIN_N),
    .RST_VAL (`TPS_PIN_RST)
  ) u_pin_sync (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .pin_in  (pin_raw),
    .pin_out (pin_sync)
  );

  assign inhibit_s      = pin_sync[`TPS_PIN_LETTER];
  assign power_down_s   = pin_sync[`TPS_PIN_PD];
  assign drive_enable_s = pin_sync[`TPS_PIN_DRIVE];
  assign node_above_s   = pin_sync[`TPS_PIN_ST];
  assign crystal_s      = pin_sync[`TPS_PIN_CRY];

  assign run = ~power_down_s;

  // -------------------------------------------------------------------
  // crystal-rate oscillator
  // -------------------------------------------------------------------
  // fractional accumulator: one tick per crystal period on average,
  // with up to one mclk of jitter on each tick
  // crystal rate ticks
  assign acc_sum  = {1'b0, acc_reg} + {1'b0, `TPS_CRYSTAL_HZ};
  assign acc_wrap = (acc_sum >= {1'b0, `TPS_MCLK_HZ});
  assign acc_next = acc_wrap ? `TPS_ACC_W'(acc_sum - {1'b0, `TPS_MCLK_HZ})
                             : `TPS_ACC_W'(acc_sum);
  assign osc_tick = run & acc_wrap;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_reg     <= '0;
      osc_out_reg <= 1'b0;
    end
    else if (run)
    begin
      acc_reg     <= acc_next;
      osc_out_reg <= ~crystal_s;
    end
    else
    begin
      osc_out_reg <= 1'b0;
    end
  end

  assign crystal_out = osc_out_reg;

  // -------------------------------------------------------------------
  // key encoding and early flag
  // -------------------------------------------------------------------
  tps_key_encoder u_key_encoder (
    .present (tone_present),
    .row     (tone_row),
    .col     (tone_col),
    .det     (det)
  );

  assign pair_ok = det.present & ~(det.letter & inhibit_s);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      early_reg <= 1'b0;
    else if (run)
      early_reg <= pair_ok;
  end

  assign early_valid_flag = early_reg;

  // -------------------------------------------------------------------
  // pending pair
  // -------------------------------------------------------------------
  // a fresh detection in the registering cycle wins over the consume
  assign pend_valid_next = pair_ok | (pend_valid_reg & ~do_register);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_code_reg  <= `TPS_CODE_RST;
      pend_valid_reg <= 1'b0;
    end
    else if (run)
    begin
      pend_valid_reg <= pend_valid_next;
      if (pair_ok)
        pend_code_reg <= det.code;
    end
  end

  // -------------------------------------------------------------------
  // steering state machine
  // -------------------------------------------------------------------
  // register on node above
  assign do_register = (steer_reg == tps_st_free) & node_above_s & pend_valid_reg;
  assign settle_done = (settle_reg == '0) & osc_tick;

  always_comb
  begin
    steer_next  = steer_reg;
    settle_next = settle_reg;
    late_next   = late_reg;
    latch_next  = latch_reg;
    unique case (steer_reg)
      tps_st_free:
      begin
        late_next = 1'b0;
        if (do_register)
        begin
          latch_next  = pend_code_reg;
          settle_next = SETTLE_LOAD;
          steer_next  = tps_st_settle;
        end
      end
      tps_st_settle:
      begin
        if (!node_above_s)
          steer_next = tps_st_free;
        else if (settle_done)
        begin
          late_next  = 1'b1;
          steer_next = tps_st_valid;
        end
        else if (osc_tick)
          settle_next = `TPS_SETTLE_W'(settle_reg - `TPS_SETTLE_W'(1));
      end
      tps_st_valid:
      begin
        if (!node_above_s)
        begin
          late_next  = 1'b0;
          steer_next = tps_st_free;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      steer_reg  <= tps_st_free;
      settle_reg <= '0;
      late_reg   <= 1'b0;
      latch_reg  <= `TPS_CODE_RST;
    end
    else if (run)
    begin
      steer_reg  <= steer_next;
      settle_reg <= settle_next;
      late_reg   <= late_next;
      latch_reg  <= latch_next;
    end
  end

  assign late_valid_flag = late_reg;

  // -------------------------------------------------------------------
  // guard drive
  // -------------------------------------------------------------------
  // driven only where flag and node agree; otherwise released so the
  // external rc sets the guard times in both directions
  // joint guard level
  assign guard_level_next = early_reg & node_above_s;
  assign guard_oe_n_next  = ~((early_reg & node_above_s & (steer_reg != tps_st_free))
                              | (~early_reg & ~node_above_s));

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      guard_level_reg <= 1'b0;
      guard_oe_n_reg  <= 1'b1;
    end
    else if (run)
    begin
      guard_level_reg <= guard_level_next;
      guard_oe_n_reg  <= guard_oe_n_next;
    end
    else
    begin
      guard_oe_n_reg  <= 1'b1;
    end
  end

  assign guard_drive      = guard_level_reg;
  assign guard_drive_oe_n = guard_oe_n_reg;

  // -------------------------------------------------------------------
  // code output bus
  // -------------------------------------------------------------------
  // enable follows the pin even while powered down, so the bus can be
  // read out of a halted device
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      code_oe_n_reg <= 1'b1;
    else
      code_oe_n_reg <= ~drive_enable_s;
  end

  assign key_code_out  = latch_reg;
  assign key_code_oe_n = code_oe_n_reg;
endmodule // tone_pair_steering_latch

/* verilog/tps_map.svh */
// constants for the tone pair steering latch
`ifndef TPS_MAP_SVH
`define TPS_MAP_SVH

// -------------------------------------------------------------------
// clocks
// -------------------------------------------------------------------
// crystal rate 3.579545 MHz, in hertz
`define TPS_CRYSTAL_HZ        25'h0369E99
// system clock rate 10 MHz, in hertz
`define TPS_MCLK_HZ           25'h0989680
`define TPS_ACC_W             25

// -------------------------------------------------------------------
// timing
// -------------------------------------------------------------------
// latch settling time before the late flag rises, in ns
`define TPS_SETTLE_NS         64'd1000
// least time, rounded up to whole crystal ticks
`define TPS_SETTLE_TICKS \
  ((`TPS_SETTLE_NS * 64'd3579545 + 64'd999999999) / 64'd1000000000)
`define TPS_SETTLE_W          8

// -------------------------------------------------------------------
// code layout and key codes
// -------------------------------------------------------------------
`define TPS_CODE_W            4
`define TPS_CODE_RST          4'h0
`define TPS_CODE_ZERO         4'hA
`define TPS_CODE_STAR         4'hB
`define TPS_CODE_HASH         4'hC
`define TPS_CODE_LETTER_BASE  4'hD
`define TPS_CODE_D            4'h0
`define TPS_LETTER_COL        2'h3
`define TPS_BOTTOM_ROW        2'h3

// -------------------------------------------------------------------
// pin synchroniser bit positions
// -------------------------------------------------------------------
`define TPS_PIN_LETTER        0
`define TPS_PIN_PD            1
`define TPS_PIN_DRIVE         2
`define TPS_PIN_ST            3
`define TPS_PIN_CRY           4
`define TPS_PIN_N             5
// reset levels: output enable pulled up, the rest low
`define TPS_PIN_RST           5'h04

`endif

/* verilog/tps_pkg.sv */
// types for the tone pair steering latch
package tps_pkg;
`include "tps_map.svh"

  typedef logic [`TPS_CODE_W-1:0] tps_code_t;
  typedef logic [1:0]             tps_index_t;

  typedef enum logic [1:0] {
    tps_st_free,
    tps_st_settle,
    tps_st_valid
  } tps_steer_t;

endpackage

/* verilog/tps_detect_if.sv */
// detected tone pair carried from the key encoder to the steering logic
`timescale 1ns/1ps
interface tps_detect_if;
  import tps_pkg::*;

  logic      present;
  tps_code_t code;
  logic      letter;

  modport src (output present, output code, output letter);
  modport snk (input present, input code, input letter);
endinterface

/* verilog/tps_pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module tps_pin_sync #(
  parameter int         WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_next;

  // a bit moves only once the second and third stage agree
  assign out_next = (s2_reg & s3_reg) | (pin_out & (s2_reg | s3_reg));

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg  <= RST_VAL;
      s2_reg  <= RST_VAL;
      s3_reg  <= RST_VAL;
      pin_out <= RST_VAL;
    end
    else
    begin
      s1_reg  <= pin_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      pin_out <= out_next;
    end
  end
endmodule // tps_pin_sync

/* verilog/tps_key_encoder.sv */
// maps the detected row and column of a tone pair to its 4-bit key code
`timescale 1ns/1ps
`include "tps_map.svh"
module tps_key_encoder (
  input  wire logic             present,
  input  wire tps_pkg::tps_index_t row,
  input  wire tps_pkg::tps_index_t col,
  tps_detect_if.src             det
);
  import tps_pkg::*;

  // rows 0..3 and columns 0..3 of the keypad; column 3 holds the letters
  function automatic tps_code_t key_code(input tps_index_t r, input tps_index_t c);
    tps_code_t v;
    v = `TPS_CODE_RST;
    if (c == `TPS_LETTER_COL)
    begin
      if (r == 2'h3)
        v = `TPS_CODE_D;
      else
        v = tps_code_t'(`TPS_CODE_LETTER_BASE + {2'h0, r});
    end
    else if (r == `TPS_BOTTOM_ROW)
    begin
      if (c == 2'h0)
        v = `TPS_CODE_STAR;
      else if (c == 2'h1)
        v = `TPS_CODE_ZERO;
      else
        v = `TPS_CODE_HASH;
    end
    else
      v = tps_code_t'({r, 2'h0} - {2'h0, r} + {2'h0, c} + 4'h1);
    return v;
  endfunction

  assign det.code    = key_code(row, col);
  assign det.letter  = (col == `TPS_LETTER_COL);
  assign det.present = present;
endmodule // tps_key_encoder

/* testbench/tps_host_model.sv */
// host side model: steering rc node, crystal loop and code bus
`timescale 1ns/1ps
module tps_host_model #(
  parameter int RC_MAX = 20,
  parameter int RC_THR = 10
) (
  input  wire logic               mclk,
  input  wire logic               early_valid_flag,
  input  wire logic               guard_drive,
  input  wire logic               guard_drive_oe_n,
  input  wire logic               crystal_out,
  input  wire tps_pkg::tps_code_t key_code_out,
  input  wire logic               key_code_oe_n,
  output logic                    crystal_in,
  output logic                    timing_node_in,
  output tps_pkg::tps_code_t      bus_seen
);
  import tps_pkg::*;
  int        charge = 0;
  tps_code_t last = '0;

  // a driven guard pin wins over the slow path from the early flag
  always @(posedge mclk)
  begin
    if (!guard_drive_oe_n)
      charge <= guard_drive ? RC_MAX : 0;
    else if (early_valid_flag)
      charge <= (charge < RC_MAX) ? charge + 1 : RC_MAX;
    else
      charge <= (charge > 0) ? charge - 1 : 0;
    if (!key_code_oe_n)
      last <= key_code_out;
  end

  assign timing_node_in = charge >= RC_THR;
  assign crystal_in     = crystal_out;
  // a floating bus reads back stale, so show the inverse of the last value
  assign bus_seen       = key_code_oe_n ? ~last : key_code_out;
endmodule // tps_host_model

/* testbench/tps_steer_asserts.sv */
// port assertions for the steering latch
`timescale 1ns/1ps
module tps_steer_asserts #(
  parameter int SETTLE_TICKS = 4
) (
  input wire logic                mclk,
  input wire logic                rst_n,
  input wire logic                power_down_in,
  input wire logic                letter_tone_inhibit,
  input wire logic                output_drive_enable,
  input wire logic                tone_present,
  input wire tps_pkg::tps_index_t tone_col,
  input wire logic                timing_node_in,
  input wire logic                guard_drive,
  input wire logic                guard_drive_oe_n,
  input wire tps_pkg::tps_code_t  key_code_out,
  input wire logic                key_code_oe_n,
  input wire logic                early_valid_flag,
  input wire logic                late_valid_flag,
  input wire logic                crystal_out
);
  import tps_pkg::*;
  localparam int LATE_MAX = 3 * (SETTLE_TICKS + 1) + 6;
  // pins cross a synchroniser, so a level is trusted only after 7 steady edges
  logic [2:0] pd_lo, pd_hi, let_lo, let_hi, oe_lo, oe_hi, node_lo;
  logic       run;
  assign run = pd_lo == 3'h7;

  function automatic logic [2:0] up(logic [2:0] c);
    return (c == 3'h7) ? c : c + 3'h1;
  endfunction

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {pd_lo, pd_hi, let_lo, let_hi} <= '0;
      {oe_lo, oe_hi, node_lo} <= '0;
    end
    else
    begin
      pd_lo   <= power_down_in ? 3'h0 : up(pd_lo);
      pd_hi   <= power_down_in ? up(pd_hi) : 3'h0;
      let_lo  <= letter_tone_inhibit ? 3'h0 : up(let_lo);
      let_hi  <= letter_tone_inhibit ? up(let_hi) : 3'h0;
      oe_lo   <= output_drive_enable ? 3'h0 : up(oe_lo);
      oe_hi   <= output_drive_enable ? up(oe_hi) : 3'h0;
      node_lo <= timing_node_in ? 3'h0 : up(node_lo);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_settle;
    !late_valid_flag ##[2:LATE_MAX] late_valid_flag;
  endsequence

  a_early_rise:
    assert property (run && tone_present && (tone_col != 2'h3 || let_lo == 3'h7)
      |=> early_valid_flag) else $error("early flag missed a tone");
  a_early_drop:
    assert property (run && !tone_present |=> !early_valid_flag)
      else $error("early flag outlived the tone");
  a_letter_block:
    assert property (run && tone_present && tone_col == 2'h3 && let_hi == 3'h7
      |=> !early_valid_flag) else $error("inhibited letter detected");
  a_bus_enable:
    assert property (oe_lo == 3'h7 || oe_hi == 3'h7 |-> key_code_oe_n == (oe_lo == 3'h7))
      else $error("code bus enable wrong");
  a_code_then_late:
    assert property ($changed(key_code_out) |-> s_settle)
      else $error("late flag not raised after latch update");
  a_late_settle:
    assert property ($rose(late_valid_flag) |-> $stable(key_code_out)
      && $past(key_code_out, 2) == key_code_out) else $error("late flag before settle");
  a_late_drop:
    assert property (run && $fell(timing_node_in) |-> ##[1:7] !late_valid_flag)
      else $error("late flag stayed after node fell");
  a_guard_high:
    assert property (run && late_valid_flag && $past(late_valid_flag)
      && $past(early_valid_flag) |-> guard_drive && !guard_drive_oe_n)
      else $error("guard not driven high");
  a_guard_low:
    assert property (run && node_lo == 3'h7 && !$past(early_valid_flag)
      |-> !guard_drive && !guard_drive_oe_n) else $error("guard not driven low");
  a_pd_halt:
    assert property (pd_hi == 3'h7 |-> !crystal_out && guard_drive_oe_n
      && $stable(early_valid_flag) && $stable(key_code_out)) else $error("power down ran");
endmodule // tps_steer_asserts

bind tone_pair_steering_latch tps_steer_asserts #(.SETTLE_TICKS(SETTLE_TICKS)) tps_sa_inst (
  .mclk(mclk), .rst_n(rst_n), .power_down_in(power_down_in),
  .letter_tone_inhibit(letter_tone_inhibit), .output_drive_enable(output_drive_enable),
  .tone_present(tone_present), .tone_col(tone_col), .timing_node_in(timing_node_in),
  .guard_drive(guard_drive), .guard_drive_oe_n(guard_drive_oe_n),
  .key_code_out(key_code_out), .key_code_oe_n(key_code_oe_n),
  .early_valid_flag(early_valid_flag), .late_valid_flag(late_valid_flag),
  .crystal_out(crystal_out));

/* testbench/testbench.sv */
// self-checking bench for the steering latch
`timescale 1ns/1ps
module testbench;
  import tps_pkg::*;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic       pd = 1'b0;
  logic       lt_block = 1'b0;
  logic       drive_en = 1'b1;
  logic       tp = 1'b0;
  tps_index_t row = '0;
  tps_index_t col = '0;
  logic       xi, xo, node, gd, gd_oe_n, code_oe_n, early, late;
  tps_code_t  code, bus;
  int         n_mismatch = 0;
  int         compares = 0;

  always #50 mclk = ~mclk;

  tone_pair_steering_latch tone_pair_steering_latch_inst (
    .mclk(mclk), .rst_n(rst_n), .power_down_in(pd), .letter_tone_inhibit(lt_block),
    .output_drive_enable(drive_en), .crystal_in(xi), .crystal_out(xo), .tone_present(tp),
    .tone_row(row), .tone_col(col), .timing_node_in(node), .guard_drive(gd),
    .guard_drive_oe_n(gd_oe_n), .key_code_out(code), .key_code_oe_n(code_oe_n),
    .early_valid_flag(early), .late_valid_flag(late));

  tps_host_model tps_host_model_inst (
    .mclk(mclk), .early_valid_flag(early), .guard_drive(gd), .guard_drive_oe_n(gd_oe_n),
    .crystal_out(xo), .key_code_out(code), .key_code_oe_n(code_oe_n), .crystal_in(xi),
    .timing_node_in(node), .bus_seen(bus));

  task automatic chk(string nm, logic [3:0] seen, logic [3:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic wait_late(logic v);
    int i;
    i = 0;
    while (late !== v && i < 200)
    begin
      cyc(1);
      i++;
    end
    chk("late", 4'(late), 4'(v));
  endtask

  // expected code per key, one nibble each, row-major from key 1 upwards:
  // 1 2 3 A / 4 5 6 B / 7 8 9 C / * 0 # D
  localparam logic [63:0] KEY_TAB = 64'h0CABF987E654D321;

  function automatic logic [3:0] key_exp(tps_index_t r, tps_index_t c);
    return KEY_TAB[{r, c, 2'b00} +: 4];
  endfunction

  task automatic press(tps_index_t r, tps_index_t c);
    row = r;
    col = c;
    tp = 1'b1;
    cyc(2);
    chk("early", 4'(early), 4'h1);
    wait_late(1'b1);
    chk("code", code, key_exp(r, c));
    tp = 1'b0;
    cyc(2);
    chk("early", 4'(early), 4'h0);
    wait_late(1'b0);
  endtask

  // all sixteen keys, back to back
  task automatic t_keys;
    for (int i = 0; i < 16; i++)
    begin
      press(i[3:2], i[1:0]);
      chk("bus", bus, key_exp(i[3:2], i[1:0]));
    end
  endtask

  task automatic t_inhibit;
    press(2'h2, 2'h2);
    lt_block = 1'b1;
    cyc(8);
    row = 2'h1;
    col = 2'h3;
    tp = 1'b1;
    cyc(40);
    chk("early", 4'(early), 4'h0);
    chk("code", code, 4'h9);
    tp = 1'b0;
    cyc(2);
    press(2'h0, 2'h1);
    lt_block = 1'b0;
  endtask

  // latch keeps updating while the bus is released
  task automatic t_oe;
    drive_en = 1'b0;
    cyc(8);
    chk("oe_n", 4'(code_oe_n), 4'h1);
    chk("bus", bus, ~key_exp(2'h0, 2'h1));
    press(2'h0, 2'h0);
    drive_en = 1'b1;
    cyc(8);
    chk("bus", bus, 4'h1);
  endtask

  task automatic t_pd;
    row = 2'h1;
    col = 2'h1;
    tp = 1'b1;
    wait_late(1'b1);
    chk("guard", 4'(gd), 4'h1);
    pd = 1'b1;
    cyc(8);
    tp = 1'b0;
    cyc(8);
    chk("xtal", 4'(xo), 4'h0);
    chk("guard_oe_n", 4'(gd_oe_n), 4'h1);
    chk("early", 4'(early), 4'h1);
    pd = 1'b0;
    wait_late(1'b0);
    chk("code", code, 4'h5);
  endtask

  initial
  begin
    cyc(4);
    rst_n = 1'b1;
    cyc(8);
    t_keys;
    t_inhibit;
    t_oe;
    t_pd;
    end_sim;
  end

  initial
  begin
    #(6000 * 100);
    n_mismatch++;
    end_sim;
  end
endmodule // testbench
